/* core/apmm_ctrl.sv */
// Coprocessor memory map, refresh, arbitration and board control.
// Assumes processor signals share clk; backplane signals come from an unrelated clock.
`timescale 1ns/100ps
`default_nettype none
module apmm_ctrl
	import apmm_pkg::*;
#(
	parameter int PAGES = 128
) (
	input wire logic clk,
	input wire logic rst_n,
	// Processor side
	output logic cpu_clk,
	input wire logic address_valid_strobe,
	input wire logic [VADDR_W-1:0] cpu_addr,
	input wire logic cpu_rnw,
	input wire logic cpu_super,
	input wire logic cpu_map_sel,
	input wire logic cpu_spurious_int,
	input wire logic [DATA_W-1:0] cpu_wdata,
	output logic [DATA_W-1:0] cpu_rdata,
	output logic cpu_ack,
	output logic cpu_halt,
	// Memory boards
	output logic [19:0] ram_addr,
	output logic [BOARD_W-1:0] ram_board,
	output logic ram_sel,
	output logic ram_we,
	output logic ram_refresh,
	output logic [DATA_W-1:0] ram_wdata,
	input wire logic [DATA_W-1:0] ram_rdata,
	input wire logic ram_par_err,
	// Backplane, I/O processor clock
	input wire logic coprocessor_space_select,
	input wire logic parallel_io_space_select,
	input wire logic backplane_read_strobe,
	input wire logic backplane_write_strobe,
	input wire logic [BP_AW-1:0] bp_addr,
	input wire logic [DATA_W-1:0] bp_wdata,
	output logic [DATA_W-1:0] bp_rdata,
	output logic bp_data_oe_n,
	output logic iop_ready
);
	// ----------------------------------------
	// Storage
	// ----------------------------------------
	apmm_state_t q; // Registered state
	apmm_state_t nxt_q; // Next state
	logic [ME_W-1:0] map_mem [PAGES]; // Map: one entry per 64 KB virtual page
	apmm_bp_t bp_raw; // Backplane bundle before crossing
	apmm_bp_t bp; // Backplane bundle after crossing

	// Even parity over entry body; stored bit makes the word even
	function automatic logic ent_par(input logic [ME_W-1:0] e);
		ent_par = ^e[ME_W-2:0];
	endfunction

	// Classify a mapped access; bit order matches the fault word
	function automatic logic [F_W-1:0] chk(input logic [ME_W-1:0] e, input logic sup);
		chk = '0;
		chk[F_MAP_PAR] = ent_par(e) != e[ME_PAR];
		chk[F_PAGE] = e[ME_BOARD_LSB +: BOARD_W] > BOARD_MAX;
		chk[F_PROT] = sup ? e[ME_NOSUPER] : e[ME_NOUSER];
	endfunction

	// ----------------------------------------
	// Backplane crossing
	// ----------------------------------------
	// Data and address pass through the same two-stage synchroniser as the selects, in the same cycles
	assign bp_raw = '{ap_sel: coprocessor_space_select, pio_sel: parallel_io_space_select,
		rd: backplane_read_strobe, wr: backplane_write_strobe, addr: bp_addr, wdata: bp_wdata};

	apmm_sync #(
		.W($bits(apmm_bp_t))
	) u_bp_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(bp_raw),
		.q(bp)
	);

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		logic [ME_W-1:0] cpu_ent;
		logic [ME_W-1:0] iop_ent;
		logic [F_W-1:0] cpu_f;
		logic [F_W-1:0] iop_f;
		logic [F_W-1:0] set_f;
		logic [PAGE_W-1:0] iop_page;
		logic iop_req;
		logic pio_req;
		logic cpu_req;
		logic clr_f;
		nxt_q = q;
		set_f = '0;
		clr_f = 1'b0;
		iop_page = q.win_page + {{(PAGE_W-1){1'b0}}, bp.addr[BP_AW-1]}; // Window spans two pages of words
		cpu_ent = map_mem[cpu_addr[VADDR_W-1 -: PAGE_W]];
		iop_ent = map_mem[iop_page];
		cpu_f = chk(cpu_ent, cpu_super);
		iop_f = chk(iop_ent, 1'b1);
		cpu_req = address_valid_strobe && !cpu_map_sel && !q.halt && !q.cpu_ack;
		iop_req = bp.ap_sel && (bp.rd || bp.wr) && !q.iop_done;
		pio_req = bp.pio_sel && (bp.rd || bp.wr) && !q.iop_done && bp.addr[BP_AW-1:3] == CSR_BASE;
		nxt_q.map_we = 1'b0;

		// Processor clock: divide by four
		nxt_q.div = q.div + 2'h1;
		nxt_q.cpu_clk = q.div[1];

		// Refresh interval timer; pending stays until the arbiter takes it
		if (q.ref_tmr == 12'(REFRESH_INT_CYC - 1)) begin
			nxt_q.ref_tmr = '0;
			nxt_q.ref_pend = 1'b1;
		end else begin
			nxt_q.ref_tmr = q.ref_tmr + 12'h1;
		end

		// Strobe released: drop the answer so the next access can start
		if (!address_valid_strobe) begin
			nxt_q.cpu_ack = 1'b0;
		end
		if (!(bp.ap_sel || bp.pio_sel) || !(bp.rd || bp.wr)) begin
			nxt_q.iop_done = 1'b0;
			nxt_q.iop_ready = 1'b0;
			nxt_q.bp_oe_n = 1'b1;
		end

		// Map access: write goes through the write latch; read data goes straight to cpu_rdata, and the read latch keeps a copy
		if (address_valid_strobe && cpu_map_sel && !q.cpu_ack && !q.halt) begin
			nxt_q.cpu_ack = 1'b1;
			if (cpu_rnw) begin
				nxt_q.map_rd_latch = map_mem[cpu_addr[PAGE_W:1]];
				nxt_q.cpu_rdata = DATA_W'(map_mem[cpu_addr[PAGE_W:1]]);
			end else begin
				nxt_q.map_wr_latch = {ent_par(cpu_wdata[ME_W-1:0]), cpu_wdata[ME_W-2:0]};
				nxt_q.map_page = cpu_addr[PAGE_W:1];
				nxt_q.map_we = 1'b1;
			end
		end

		// Control and status words; they never touch RAM so need no arbitration
		if (pio_req) begin
			nxt_q.iop_done = 1'b1;
			nxt_q.iop_ready = 1'b1;
			if (bp.wr && bp.addr[2:0] == CSR_CTRL) begin
				nxt_q.win_page = bp.wdata[CTRL_WIN_LSB +: PAGE_W];
				clr_f = bp.wdata[CTRL_CLR];
				if (bp.wdata[CTRL_RUN]) begin
					nxt_q.halt = 1'b0;
				end
			end else if (bp.rd) begin
				nxt_q.bp_oe_n = 1'b0;
				if (bp.addr[2:0] == CSR_FAULT) begin
					nxt_q.bp_rdata = DATA_W'(q.faults);
				end else if (bp.addr[2:0] == CSR_PINS) begin
					nxt_q.bp_rdata = DATA_W'({q.halt, cpu_super, cpu_rnw, address_valid_strobe});
				end else if (bp.addr[2:0] == CSR_FPAGE) begin
					nxt_q.bp_rdata = DATA_W'(q.fault_page);
				end else begin
					nxt_q.bp_rdata = {1'b0, q.win_page, 6'h0, q.halt, 1'b0};
				end
			end
		end

		// Arbiter: one RAM cycle at a time, refresh first, then backplane, then processor
		case (q.st)
			ST_IDLE: begin
				nxt_q.cnt = '0;
				if (q.ref_pend) begin
					nxt_q.st = ST_REF;
					nxt_q.ref_pend = 1'b0;
					nxt_q.ram_sel = 1'b1;
					nxt_q.ram_refresh = 1'b1;
					nxt_q.ram_we = 1'b0;
					nxt_q.ram_addr = {12'h000, q.ref_row};
				end else if (iop_req) begin
					nxt_q.iop_done = 1'b1;
					if (|iop_f) begin
						set_f = iop_f;
						nxt_q.fault_page = iop_page;
						nxt_q.iop_ready = 1'b1;
						nxt_q.bp_rdata = '0;
						nxt_q.bp_oe_n = !bp.rd;
					end else begin
						nxt_q.st = ST_IOP;
						nxt_q.ram_sel = 1'b1;
						nxt_q.ram_we = bp.wr;
						nxt_q.ram_board = iop_ent[ME_BOARD_LSB +: BOARD_W];
						nxt_q.ram_addr = {iop_ent[ME_FRAME_LSB +: FRAME_W], 1'b0, bp.addr[BP_AW-2:0], 1'b0};
						nxt_q.ram_wdata = bp.wdata;
					end
				end else if (cpu_req) begin
					if (|cpu_f) begin
						set_f = cpu_f;
						nxt_q.fault_page = cpu_addr[VADDR_W-1 -: PAGE_W];
					end else begin
						nxt_q.st = ST_CPU;
						nxt_q.ram_sel = 1'b1;
						nxt_q.ram_we = !cpu_rnw;
						nxt_q.ram_board = cpu_ent[ME_BOARD_LSB +: BOARD_W];
						nxt_q.ram_addr = {cpu_ent[ME_FRAME_LSB +: FRAME_W], cpu_addr[OFFS_W-1:0]};
						nxt_q.ram_wdata = cpu_wdata;
					end
				end
			end
			ST_CPU, ST_IOP, ST_REF: begin
				nxt_q.cnt = q.cnt + 6'h1;
				if (q.cnt == 6'(RAM_CYC - 1)) begin
					nxt_q.st = ST_IDLE;
					nxt_q.ram_sel = 1'b0;
					nxt_q.ram_we = 1'b0;
					nxt_q.ram_refresh = 1'b0;
					if (q.st == ST_REF) begin
						nxt_q.ref_row = q.ref_row + 8'h1;
					end else if (!q.ram_we && ram_par_err) begin
						set_f[F_RAM_PAR] = 1'b1;
						nxt_q.fault_page = q.st == ST_CPU ? cpu_addr[VADDR_W-1 -: PAGE_W] : iop_page;
					end
					if (q.st == ST_CPU) begin
						nxt_q.cpu_ack = 1'b1;
						nxt_q.cpu_rdata = ram_rdata;
					end else if (q.st == ST_IOP) begin
						nxt_q.iop_ready = 1'b1;
						nxt_q.bp_rdata = ram_rdata;
						nxt_q.bp_oe_n = q.ram_we;
					end
				end
			end
			default: begin
				nxt_q.st = ST_IDLE;
			end
		endcase

		// Fault capture; a new fault wins over a clear in the same cycle
		set_f[F_SPUR] = set_f[F_SPUR] | cpu_spurious_int;
		nxt_q.faults = (clr_f ? '0 : q.faults) | set_f;
		if (|set_f) begin
			nxt_q.halt = 1'b1;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
			q.st <= ST_IDLE;
			q.bp_oe_n <= 1'b1;
		end else begin
			q <= nxt_q;
		end
	end

	// Map array has no reset: processor software loads it with map writes before its first mapped access
	always_ff @(posedge clk) begin
		if (q.map_we) begin
			map_mem[q.map_page] <= q.map_wr_latch;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------
	assign cpu_clk = q.cpu_clk;
	assign cpu_rdata = q.cpu_rdata;
	assign cpu_ack = q.cpu_ack;
	assign cpu_halt = q.halt;
	assign ram_addr = q.ram_addr;
	assign ram_board = q.ram_board;
	assign ram_sel = q.ram_sel;
	assign ram_we = q.ram_we;
	assign ram_refresh = q.ram_refresh;
	assign ram_wdata = q.ram_wdata;
	assign bp_rdata = q.bp_rdata;
	assign bp_data_oe_n = q.bp_oe_n;
	assign iop_ready = q.iop_ready;
endmodule
`default_nettype wire

/* common/apmm_pkg.sv */
// Shared constants, state and struct types for the coprocessor memory map block.
// Assumes one 250 MHz clock drives all of the map, refresh and board-control logic.
package apmm_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ = 250; // Board clock rate
	localparam int REFRESH_PERIOD_US = 4000; // Longest time for all rows to be refreshed
	localparam int REFRESH_ROWS = 256; // Rows per dynamic RAM
	localparam int REFRESH_INT_CYC = REFRESH_PERIOD_US * CLK_MHZ / REFRESH_ROWS; // Longest: rounds down
	localparam int RAM_ACCESS_NS = 150; // RAM cycle time
	localparam int RAM_CYC = (RAM_ACCESS_NS * CLK_MHZ + 999) / 1000; // Least: rounds up
	localparam int CPU_CLK_DIV = 4; // Processor clock divide ratio

	// ----------------------------------------
	// Address geometry
	// ----------------------------------------
	localparam int VADDR_W = 23; // Processor address bus width
	localparam int PAGE_W = 7; // Map index: 64 KB pages
	localparam int OFFS_W = 16; // Byte offset within a page
	localparam int FRAME_W = 4; // Page frame within a 1 MB board
	localparam int BOARD_W = 3; // Board number field
	localparam logic [2:0] BOARD_MAX = 3'h5; // Boards 0..5 exist
	localparam int BP_AW = 15; // Backplane word address width
	localparam int DATA_W = 16; // Data bus width

	// ----------------------------------------
	// Map entry layout: {parity, no_super, no_user, board, frame}
	// ----------------------------------------
	localparam int ME_FRAME_LSB = 0;
	localparam int ME_BOARD_LSB = 4;
	localparam int ME_NOUSER = 7;
	localparam int ME_NOSUPER = 8;
	localparam int ME_PAR = 9;
	localparam int ME_W = 10;

	// ----------------------------------------
	// Control/status words in the parallel I/O space (word index)
	// ----------------------------------------
	localparam logic [11:0] CSR_BASE = 12'h000; // bp_addr[14:3] that selects this board
	localparam logic [2:0] CSR_CTRL = 3'h0; // W: [0] run, [1] clear faults; [14:8] window page
	localparam logic [2:0] CSR_FAULT = 3'h1; // R: fault word
	localparam logic [2:0] CSR_PINS = 3'h2; // R: processor pin states
	localparam logic [2:0] CSR_FPAGE = 3'h3; // R: page of last fault
	localparam int CTRL_RUN = 0;
	localparam int CTRL_CLR = 1;
	localparam int CTRL_WIN_LSB = 8;

	// Fault word bit positions
	localparam int F_RAM_PAR = 0;
	localparam int F_MAP_PAR = 1;
	localparam int F_PAGE = 2;
	localparam int F_PROT = 3;
	localparam int F_SPUR = 4;
	localparam int F_W = 5;

	// ----------------------------------------
	// Arbiter states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_CPU = 4'h2,
		ST_IOP = 4'h4,
		ST_REF = 4'h8
	} apmm_st_t;

	// Backplane inputs after synchronising
	typedef struct packed {
		logic ap_sel;
		logic pio_sel;
		logic rd;
		logic wr;
		logic [BP_AW-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} apmm_bp_t;

	// Register state of the top module, apart from the map array
	typedef struct packed {
		apmm_st_t st;
		logic [5:0] cnt;
		logic [1:0] div;
		logic cpu_clk;
		logic [11:0] ref_tmr;
		logic ref_pend;
		logic [7:0] ref_row;
		logic halt;
		logic [F_W-1:0] faults;
		logic [PAGE_W-1:0] fault_page;
		logic [PAGE_W-1:0] win_page;
		logic [ME_W-1:0] map_rd_latch;
		logic [ME_W-1:0] map_wr_latch;
		logic map_we;
		logic [PAGE_W-1:0] map_page;
		logic [19:0] ram_addr;
		logic [BOARD_W-1:0] ram_board;
		logic ram_sel;
		logic ram_we;
		logic ram_refresh;
		logic [DATA_W-1:0] ram_wdata;
		logic [DATA_W-1:0] cpu_rdata;
		logic cpu_ack;
		logic [DATA_W-1:0] bp_rdata;
		logic bp_oe_n;
		logic iop_ready;
		logic iop_done;
	} apmm_state_t;

endpackage

/* core/apmm_sync.sv */
// Two-stage synchroniser for backplane levels arriving from the I/O processor clock.
// Assumes inputs are levels held for several board clocks.
`timescale 1ns/100ps
`default_nettype none
module apmm_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	// First stage is read only by the second stage
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// ----------------------------------------
	// Double flop
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;
endmodule
`default_nettype wire

/* sim/apmm_ctrl_properties.sv */
// Port-level timing checks for the map controller.
// Assumes it is bound to apmm_ctrl from the bench top file.
`timescale 1ns/100ps
`default_nettype none
module apmm_ctrl_properties
	import apmm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cpu_clk,
	input wire logic address_valid_strobe,
	input wire logic cpu_spurious_int,
	input wire logic cpu_ack,
	input wire logic cpu_halt,
	input wire logic [19:0] ram_addr,
	input wire logic ram_sel,
	input wire logic ram_refresh,
	input wire logic coprocessor_space_select,
	input wire logic parallel_io_space_select,
	input wire logic iop_ready
);
	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic [5:0] len_ff; // Length of the running RAM cycle
	logic [12:0] gap_ff; // Cycles since a refresh began
	// Counters restart at reset so no stale length leaks over
	always_ff @(posedge clk) begin
		len_ff <= (rst_n && ram_sel) ? len_ff + 6'h01 : 6'h00;
		gap_ff <= (!rst_n || $rose(ram_refresh)) ? 13'h0000 : gap_ff + 13'h0001;
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_edge;
		!$stable(cpu_clk);
	endsequence
	// Two cycles per level of the processor clock
	property p_clk_div;
		s_edge |=> $stable(cpu_clk) ##1 !$stable(cpu_clk);
	endproperty
	a_clk_div: assert property (p_clk_div) else $error("processor clock period wrong");
	property p_ref_addr;
		ram_sel && ram_refresh |-> ram_addr[19:8] == 12'h000;
	endproperty
	a_ref_addr: assert property (p_ref_addr) else $error("refresh address not a row");
	// Slack covers one RAM cycle already running
	property p_ref_gap;
		gap_ff <= 13'h1004;
	endproperty
	a_ref_gap: assert property (p_ref_gap) else $error("refresh came too late");
	property p_ram_len;
		$fell(ram_sel) |-> len_ff == 6'h26;
	endproperty
	a_ram_len: assert property (p_ram_len) else $error("RAM cycle length wrong");
	property p_ack_src;
		$rose(cpu_ack) |-> address_valid_strobe && $past(address_valid_strobe);
	endproperty
	a_ack_src: assert property (p_ack_src) else $error("ack without request");
	sequence s_idle;
		(!coprocessor_space_select && !parallel_io_space_select) [*5];
	endsequence
	property p_ready;
		s_idle |-> !iop_ready;
	endproperty
	a_ready: assert property (p_ready) else $error("ready without select");
	sequence s_quiet;
		(!parallel_io_space_select) [*5] ##0 $past(cpu_halt);
	endsequence
	property p_halt_hold;
		s_quiet |-> cpu_halt;
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("halt dropped by itself");
	property p_spur;
		cpu_spurious_int |-> ##[1:3] cpu_halt;
	endproperty
	a_spur: assert property (p_spur) else $error("spurious interrupt did not halt");
	property p_reset;
		disable iff (1'b0) !rst_n |=> !cpu_ack && !ram_sel && !cpu_halt && !iop_ready;
	endproperty
	a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

/* sim/apmm_iop_model.sv */
// Behavioural I/O processor driving the backplane on its own clock.
// Assumes the bench calls xfer for one transfer at a time.
`timescale 1ns/100ps
`default_nettype none
module apmm_iop_model
	import apmm_pkg::*;
(
	output logic coprocessor_space_select,
	output logic parallel_io_space_select,
	output logic backplane_read_strobe,
	output logic backplane_write_strobe,
	output logic [BP_AW-1:0] bp_addr,
	output logic [DATA_W-1:0] bp_wdata,
	input wire logic [DATA_W-1:0] bp_rdata,
	input wire logic iop_ready
);
	logic iclk = 1'b0; // Unrelated to the board clock
	always #3.7 iclk = ~iclk;
	initial begin
		{coprocessor_space_select, parallel_io_space_select} = 2'h0;
		{backplane_read_strobe, backplane_write_strobe} = 2'h0;
		bp_addr = 15'h7FFF;
		bp_wdata = 16'hFFFF;
	end
	// Request held whole until ready or 150 clocks; released address and data show the inverse
	task automatic xfer(input logic ap, input logic rd, input logic [BP_AW-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q, output logic ok);
		int n;
		@(posedge iclk);
		bp_addr <= a;
		bp_wdata <= d;
		coprocessor_space_select <= ap;
		parallel_io_space_select <= !ap;
		backplane_read_strobe <= rd;
		backplane_write_strobe <= !rd;
		n = 0;
		do begin
			@(posedge iclk);
			n++;
		end while (iop_ready !== 1'b1 && n < 150);
		ok = (iop_ready === 1'b1);
		q = bp_rdata;
		{coprocessor_space_select, parallel_io_space_select} <= 2'h0;
		{backplane_read_strobe, backplane_write_strobe} <= 2'h0;
		bp_addr <= ~a;
		bp_wdata <= ~d;
		n = 0;
		do begin
			@(posedge iclk);
			n++;
		end while (iop_ready !== 1'b0 && n < 150);
	endtask
endmodule
`default_nettype wire

/* sim/apmm_ctrl_tb.sv */
// Bench for the map controller: map, accesses, faults, window, status words, refresh.
// Assumes the checker and the I/O processor model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module apmm_ctrl_tb
	import apmm_pkg::*;
;
	localparam logic [15:0] RD_PAT = 16'h5AC3; // Word every RAM board returns
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic address_valid_strobe = 1'b0, cpu_rnw = 1'b1, cpu_super = 1'b0, cpu_map_sel = 1'b0;
	logic cpu_spurious_int = 1'b0, ram_par_err = 1'b0;
	logic [VADDR_W-1:0] cpu_addr = 23'h000000;
	logic [DATA_W-1:0] cpu_wdata = 16'h0000;
	logic cpu_clk, cpu_ack, cpu_halt, ram_sel, ram_we, ram_refresh, bp_data_oe_n, iop_ready;
	logic coprocessor_space_select, parallel_io_space_select, backplane_read_strobe, backplane_write_strobe;
	logic [DATA_W-1:0] cpu_rdata, ram_wdata, bp_rdata, bp_wdata, m_wd, last_rd;
	logic [19:0] ram_addr, m_addr; // m_ holds the last non-refresh RAM cycle
	logic [BOARD_W-1:0] ram_board, m_board;
	logic [BP_AW-1:0] bp_addr;
	logic m_we, ref_q = 1'b0, oe_seen = 1'b1; // oe_seen: data enable while ready stands
	logic [7:0] rows [$]; // Rows seen at each refresh start
	int n_fail = 0, n_tests = 0, cyc = 0;
	always #2 clk = ~clk;
	apmm_ctrl dut (.clk(clk), .rst_n(rst_n), .cpu_clk(cpu_clk), .address_valid_strobe(address_valid_strobe),
		.cpu_addr(cpu_addr), .cpu_rnw(cpu_rnw), .cpu_super(cpu_super), .cpu_map_sel(cpu_map_sel),
		.cpu_spurious_int(cpu_spurious_int), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
		.cpu_halt(cpu_halt), .ram_addr(ram_addr), .ram_board(ram_board), .ram_sel(ram_sel), .ram_we(ram_we),
		.ram_refresh(ram_refresh), .ram_wdata(ram_wdata), .ram_rdata(RD_PAT), .ram_par_err(ram_par_err),
		.coprocessor_space_select(coprocessor_space_select), .parallel_io_space_select(parallel_io_space_select),
		.backplane_read_strobe(backplane_read_strobe), .backplane_write_strobe(backplane_write_strobe),
		.bp_addr(bp_addr), .bp_wdata(bp_wdata), .bp_rdata(bp_rdata), .bp_data_oe_n(bp_data_oe_n),
		.iop_ready(iop_ready));
	apmm_iop_model iop (.coprocessor_space_select(coprocessor_space_select),
		.parallel_io_space_select(parallel_io_space_select), .backplane_read_strobe(backplane_read_strobe),
		.backplane_write_strobe(backplane_write_strobe), .bp_addr(bp_addr), .bp_wdata(bp_wdata),
		.bp_rdata(bp_rdata), .iop_ready(iop_ready));
	// ----------------------------------------
	// Monitor and timeout
	// ----------------------------------------
	always @(posedge clk) begin
		if (ram_sel === 1'b1 && ram_refresh === 1'b0) begin
			{m_addr, m_board, m_we, m_wd} <= {ram_addr, ram_board, ram_we, ram_wdata};
		end
		if (ram_refresh === 1'b1 && ref_q === 1'b0) rows.push_back(ram_addr[7:0]);
		ref_q <= ram_refresh;
		if (iop_ready === 1'b1) oe_seen <= bp_data_oe_n;
		cyc++;
		if (cyc == 30000) begin
			n_fail++;
			give_verdict;
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Processor access held until ack; refused ones give up after a bound
	task automatic cpu_acc(input logic ms, input logic rnw, input logic sup, input logic [22:0] a,
		input logic [15:0] d, output logic ok);
		int n;
		@(posedge clk);
		{cpu_map_sel, cpu_rnw, cpu_super, cpu_addr, cpu_wdata} <= {ms, rnw, sup, a, d};
		address_valid_strobe <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (cpu_ack !== 1'b1 && n < 120);
		ok = (cpu_ack === 1'b1);
		last_rd = cpu_rdata;
		address_valid_strobe <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic csr(input logic rd, input logic [2:0] w, input logic [15:0] d, output logic [15:0] q);
		logic ok;
		iop.xfer(1'b0, rd, {CSR_BASE, w}, d, q, ok);
		chk({15'h0000, ok}, 16'h0001);
	endtask
	// Halt and one fault bit expected; then clear and restart
	task automatic fault_end(input int fb);
		logic [15:0] q;
		chk({15'h0000, cpu_halt}, 16'h0001);
		csr(1'b1, CSR_FAULT, 16'h0000, q);
		chk(q, 16'h0001 << fb);
		csr(1'b0, CSR_CTRL, 16'h0003, q);
		csr(1'b1, CSR_FAULT, 16'h0000, q);
		@(posedge clk);
		chk({q[14:0], cpu_halt}, 16'h0000);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_map;
		logic [15:0] e [4];
		logic ok;
		e = '{16'h0025, 16'h0093, 16'h0060, 16'h0149};
		for (int p = 0; p < 4; p++) cpu_acc(1'b1, 1'b0, 1'b1, {15'h0000, 7'(p), 1'b0}, e[p], ok);
		for (int p = 0; p < 4; p++) begin
			cpu_acc(1'b1, 1'b1, 1'b1, {15'h0000, 7'(p), 1'b0}, 16'h0000, ok);
			chk(last_rd & 16'h01FF, e[p]);
		end
	endtask
	task automatic t_cpu;
		logic ok;
		cpu_acc(1'b0, 1'b0, 1'b1, {7'h00, 16'h1234}, 16'h9D61, ok);
		chk({7'h00, m_we, 1'b0, m_board, m_addr[19:16]}, 16'h0125);
		chk(m_addr[15:0], 16'h1234);
		chk(m_wd, 16'h9D61);
		cpu_acc(1'b0, 1'b1, 1'b0, {7'h03, 16'h0F0E}, 16'h0000, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(last_rd, RD_PAT);
		chk({7'h00, m_we, 1'b0, m_board, m_addr[19:16]}, 16'h0049);
	endtask
	task automatic t_fault(input logic [6:0] pg, input logic sup, input logic pe, input int fb);
		logic ok;
		logic [15:0] q;
		ram_par_err <= pe;
		cpu_acc(1'b0, 1'b1, sup, {pg, 16'h0040}, 16'h0000, ok);
		ram_par_err <= 1'b0;
		if (!pe) chk({15'h0000, ok}, 16'h0000);
		csr(1'b1, CSR_FPAGE, 16'h0000, q);
		chk(q, {9'h000, pg});
		fault_end(fb);
	endtask
	// Spurious interrupt, with the pin word read while halted
	task automatic t_spur;
		logic [15:0] q;
		@(posedge clk);
		cpu_spurious_int <= 1'b1;
		cpu_super <= 1'b1;
		@(posedge clk);
		cpu_spurious_int <= 1'b0;
		repeat (4) @(posedge clk);
		csr(1'b1, CSR_PINS, 16'h0000, q);
		chk(q & 16'h000F, 16'h000E);
		fault_end(F_SPUR);
	endtask
	task automatic t_win;
		logic [15:0] q;
		logic ok;
		iop.xfer(1'b1, 1'b0, 15'h0123, 16'hBEEF, q, ok);
		chk({7'h00, m_we, 1'b0, m_board, m_addr[19:16]}, 16'h0125);
		chk(m_addr[15:0], 16'h0246);
		chk(m_wd, 16'hBEEF);
		chk({15'h0000, oe_seen}, 16'h0001);
		iop.xfer(1'b1, 1'b1, 15'h4010, 16'h0000, q, ok);
		chk(q, RD_PAT);
		chk({15'h0000, oe_seen}, 16'h0000);
		chk({7'h00, m_we, 1'b0, m_board, m_addr[19:16]}, 16'h0013);
		iop.xfer(1'b0, 1'b1, 15'h0040, 16'h0000, q, ok);
		chk({15'h0000, ok}, 16'h0000);
		// Move the window up one page and read the control word back
		csr(1'b0, CSR_CTRL, 16'h0100, q);
		csr(1'b1, CSR_CTRL, 16'h0000, q);
		chk(q, 16'h0100);
		iop.xfer(1'b1, 1'b1, 15'h0155, 16'h0000, q, ok);
		chk({7'h00, m_we, 1'b0, m_board, m_addr[19:16]}, 16'h0013);
		chk(m_addr[15:0], 16'h02AA);
	endtask
	task automatic t_ref;
		repeat (8000) @(posedge clk);
		chk({15'h0000, rows.size() > 1}, 16'h0001);
		chk({8'h00, rows[1]}, {8'h00, rows[0] + 8'h01});
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_map;
		t_cpu;
		t_fault(7'h01, 1'b0, 1'b0, F_PROT);
		t_fault(7'h03, 1'b1, 1'b0, F_PROT);
		t_fault(7'h02, 1'b1, 1'b0, F_PAGE);
		t_fault(7'h00, 1'b1, 1'b1, F_RAM_PAR);
		t_spur;
		t_win;
		t_ref;
		give_verdict;
	end
endmodule
bind apmm_ctrl apmm_ctrl_properties u_prop (.clk(clk), .rst_n(rst_n), .cpu_clk(cpu_clk),
	.address_valid_strobe(address_valid_strobe), .cpu_spurious_int(cpu_spurious_int), .cpu_ack(cpu_ack),
	.cpu_halt(cpu_halt), .ram_addr(ram_addr), .ram_sel(ram_sel), .ram_refresh(ram_refresh),
	.coprocessor_space_select(coprocessor_space_select), .parallel_io_space_select(parallel_io_space_select),
	.iop_ready(iop_ready));
`default_nettype wire
